// File: logic/cmp_skip_branch_pkg.sv
// package: opcodes, flag positions and carriers for compare/skip/branch unit
package cmp_skip_branch_pkg;

  localparam int DATA_W = 8;
  localparam int PC_W = 16;

  // status flag bit positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;

  // amount added to PC when a skip passes a one- or two-word instruction
  localparam logic [1:0] SKIP_ONE_WORD = 2'h2;
  localparam logic [1:0] SKIP_TWO_WORD = 2'h3;

  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  typedef enum logic [3:0] {
    OP_NONE                  = 4'h0,
    OP_COMPARE_WITH_CARRY    = 4'h1,
    OP_COMPARE_IMMEDIATE     = 4'h2,
    OP_SKIP_REG_BIT_CLEAR    = 4'h3,
    OP_SKIP_REG_BIT_SET      = 4'h4,
    OP_SKIP_IO_BIT_CLEAR     = 4'h5,
    OP_SKIP_IO_BIT_SET       = 4'h6,
    OP_BRANCH_FLAG_SET       = 4'h7,
    OP_BRANCH_FLAG_CLEAR     = 4'h8,
    OP_BRANCH_EQUAL          = 4'h9,
    OP_BRANCH_NOT_EQUAL      = 4'hA,
    OP_BRANCH_CARRY_SET      = 4'hB
  } op_t;

  // one decoded instruction from the fetch path
  typedef struct packed {
    op_t op;
    logic [DATA_W-1:0] rd_val;
    logic [DATA_W-1:0] rr_val;
    logic [DATA_W-1:0] imm_k;
    logic [DATA_W-1:0] io_val;
    logic [2:0] bit_sel;
    logic [6:0] offset_k;
    logic next_is_two_word;
  } instr_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } state_t;

endpackage

// File: logic/compare_skip_branch_exec.sv
// compare, bit-skip and flag-branch execution unit
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Compare-immediate sets Z N V C H from Rd-K, storing nothing.
// - Register-bit-clear skip adds 2 or 3 to PC on a 0 bit, flags kept.
// - Register-bit-set skip adds 2 or 3 to PC on a 1 bit, flags kept.
// - IO-bit-clear skip adds 2 or 3 to PC on a 0 bit, flags kept.
// - IO-bit-set skip adds 2 or 3 to PC on a 1 bit, flags kept.
// - Flag-set branch (also equal, carry-set) loads PC+k+1 on a 1 flag.
// - Flag-clear branch (also not-equal) loads PC+k+1 on a 0 flag.
module compare_skip_branch_exec #(
  parameter int DATA_W = 8,
  parameter int PC_W = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_valid,
  input wire cmp_skip_branch_pkg::instr_t i_instr,
  input wire logic [PC_W-1:0] i_pc,
  input wire logic [7:0] i_flags,
  output logic o_busy,
  output logic o_done,
  output logic o_flags_we,
  output logic [7:0] o_flags,
  output logic o_pc_we,
  output logic [PC_W-1:0] o_pc
);

  cmp_skip_branch_pkg::state_t state_q, state_d;
  logic [1:0] wait_q, wait_d;
  logic done_q, done_d;
  logic flags_we_q, flags_we_d;
  logic [7:0] flags_q, flags_d;
  logic pc_we_q, pc_we_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic busy_q, busy_d;

  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);

  // subtract datapath shared by both compares
  logic [DATA_W-1:0] sub_b;
  logic sub_cin;
  logic [DATA_W:0] diff;
  logic [4:0] low_diff;
  logic [7:0] cmp_flags;
  logic test_bit;
  logic flag_bit;
  logic taken;
  logic [1:0] extra;
  logic [PC_W-1:0] k_ext;

  always_comb
  begin
    sub_b = i_instr.rr_val;
    sub_cin = i_flags[cmp_skip_branch_pkg::FLAG_C];
    if (i_instr.op == cmp_skip_branch_pkg::OP_COMPARE_IMMEDIATE)
    begin
      sub_b = i_instr.imm_k;
      sub_cin = 1'b0;
    end
    diff = {1'b0, i_instr.rd_val} - {1'b0, sub_b} - {8'h00, sub_cin};
    low_diff = {1'b0, i_instr.rd_val[3:0]} - {1'b0, sub_b[3:0]}
      - {4'h0, sub_cin};
    cmp_flags = i_flags;
    cmp_flags[cmp_skip_branch_pkg::FLAG_C] = diff[DATA_W];
    cmp_flags[cmp_skip_branch_pkg::FLAG_H] = low_diff[4];
    cmp_flags[cmp_skip_branch_pkg::FLAG_N] = diff[DATA_W-1];
    cmp_flags[cmp_skip_branch_pkg::FLAG_V] =
      (i_instr.rd_val[DATA_W-1] ^ sub_b[DATA_W-1])
      & (i_instr.rd_val[DATA_W-1] ^ diff[DATA_W-1]);
    cmp_flags[cmp_skip_branch_pkg::FLAG_S] =
      diff[DATA_W-1] ^ cmp_flags[cmp_skip_branch_pkg::FLAG_V];
    // carry-in form keeps Z only when result is zero
    if (i_instr.op == cmp_skip_branch_pkg::OP_COMPARE_IMMEDIATE)
      cmp_flags[cmp_skip_branch_pkg::FLAG_Z] = (diff[DATA_W-1:0] == '0);
    else
      cmp_flags[cmp_skip_branch_pkg::FLAG_Z] = (diff[DATA_W-1:0] == '0)
        & i_flags[cmp_skip_branch_pkg::FLAG_Z];
  end

  always_comb
  begin
    test_bit = i_instr.rd_val[i_instr.bit_sel];
    if (i_instr.op == cmp_skip_branch_pkg::OP_SKIP_IO_BIT_CLEAR ||
        i_instr.op == cmp_skip_branch_pkg::OP_SKIP_IO_BIT_SET)
      test_bit = i_instr.io_val[i_instr.bit_sel];
    flag_bit = i_flags[i_instr.bit_sel];
    k_ext = {{(PC_W-7){i_instr.offset_k[6]}}, i_instr.offset_k};
    taken = 1'b0;
    extra = 2'h0;
    case (i_instr.op)
      cmp_skip_branch_pkg::OP_SKIP_REG_BIT_CLEAR,
      cmp_skip_branch_pkg::OP_SKIP_IO_BIT_CLEAR:
        taken = ~test_bit;
      cmp_skip_branch_pkg::OP_SKIP_REG_BIT_SET,
      cmp_skip_branch_pkg::OP_SKIP_IO_BIT_SET:
        taken = test_bit;
      cmp_skip_branch_pkg::OP_BRANCH_FLAG_SET:
        taken = flag_bit;
      cmp_skip_branch_pkg::OP_BRANCH_FLAG_CLEAR:
        taken = ~flag_bit;
      cmp_skip_branch_pkg::OP_BRANCH_EQUAL:
        taken = i_flags[cmp_skip_branch_pkg::FLAG_Z];
      cmp_skip_branch_pkg::OP_BRANCH_NOT_EQUAL:
        taken = ~i_flags[cmp_skip_branch_pkg::FLAG_Z];
      cmp_skip_branch_pkg::OP_BRANCH_CARRY_SET:
        taken = i_flags[cmp_skip_branch_pkg::FLAG_C];
      default:
        taken = 1'b0;
    endcase
    // extra cycles beyond the first: skip 1 or 2, branch 1
    if (taken)
    begin
      if (i_instr.op >= cmp_skip_branch_pkg::OP_SKIP_REG_BIT_CLEAR &&
          i_instr.op <= cmp_skip_branch_pkg::OP_SKIP_IO_BIT_SET)
        extra = i_instr.next_is_two_word ? 2'h2 : 2'h1;
      else
        extra = 2'h1;
    end
  end

  always_comb
  begin
    state_d = state_q;
    wait_d = wait_q;
    done_d = 1'b0;
    flags_we_d = 1'b0;
    flags_d = flags_q;
    pc_we_d = 1'b0;
    pc_d = pc_q;
    case (state_q)
      cmp_skip_branch_pkg::ST_IDLE:
        if (i_valid && i_instr.op != cmp_skip_branch_pkg::OP_NONE)
        begin
          if (i_instr.op == cmp_skip_branch_pkg::OP_COMPARE_IMMEDIATE ||
              i_instr.op == cmp_skip_branch_pkg::OP_COMPARE_WITH_CARRY)
          begin
            flags_we_d = 1'b1;
            flags_d = cmp_flags;
            done_d = 1'b1;
          end
          else if (!taken)
            done_d = 1'b1;
          else
          begin
            pc_we_d = 1'b1;
            if (i_instr.op >= cmp_skip_branch_pkg::OP_BRANCH_FLAG_SET)
              pc_d = i_pc + k_ext + 16'h0001;
            else if (i_instr.next_is_two_word)
              pc_d = i_pc + {14'h0000, cmp_skip_branch_pkg::SKIP_TWO_WORD};
            else
              pc_d = i_pc + {14'h0000, cmp_skip_branch_pkg::SKIP_ONE_WORD};
            wait_d = extra - 2'h1;
            state_d = (extra == 2'h1) ? cmp_skip_branch_pkg::ST_DONE
                                      : cmp_skip_branch_pkg::ST_WAIT;
          end
        end
      cmp_skip_branch_pkg::ST_WAIT:
      begin
        wait_d = wait_q - 2'h1;
        if (wait_q == 2'h1)
          state_d = cmp_skip_branch_pkg::ST_DONE;
      end
      cmp_skip_branch_pkg::ST_DONE:
      begin
        done_d = 1'b1;
        state_d = cmp_skip_branch_pkg::ST_IDLE;
      end
      default:
        state_d = cmp_skip_branch_pkg::ST_IDLE;
    endcase
    busy_d = (state_d != cmp_skip_branch_pkg::ST_IDLE);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      state_q <= cmp_skip_branch_pkg::ST_IDLE;
      wait_q <= 2'h0;
      done_q <= 1'b0;
      flags_we_q <= 1'b0;
      flags_q <= cmp_skip_branch_pkg::FLAGS_RESET;
      pc_we_q <= 1'b0;
      pc_q <= cmp_skip_branch_pkg::PC_RESET;
      busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      wait_q <= wait_d;
      done_q <= done_d;
      flags_we_q <= flags_we_d;
      flags_q <= flags_d;
      pc_we_q <= pc_we_d;
      pc_q <= pc_d;
      busy_q <= busy_d;
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_flags_we = flags_we_q;
  assign o_flags = flags_q;
  assign o_pc_we = pc_we_q;
  assign o_pc = pc_q;

  sequence s_cmp_issue;
    i_valid && !o_busy &&
      i_instr.op == cmp_skip_branch_pkg::OP_COMPARE_IMMEDIATE;
  endsequence

  a_cpi_flags_one: assert property (
    s_cmp_issue |=> o_flags_we && o_done &&
      o_flags[cmp_skip_branch_pkg::FLAG_Z] ==
      ($past(i_instr.rd_val) == $past(i_instr.imm_k)))
    else $error("compare immediate flags wrong");

  a_cpc_flags_one: assert property (
    i_valid && !o_busy &&
    i_instr.op == cmp_skip_branch_pkg::OP_COMPARE_WITH_CARRY
    |=> o_flags_we && o_done && !o_pc_we)
    else $error("compare with carry not one cycle");

  a_skip_rbc_pc: assert property (
    i_valid && !o_busy &&
    i_instr.op == cmp_skip_branch_pkg::OP_SKIP_REG_BIT_CLEAR &&
    !i_instr.rd_val[i_instr.bit_sel] && !i_instr.next_is_two_word
    |=> o_pc_we && o_pc == $past(i_pc) + 16'h0002 ##1 o_done)
    else $error("register bit clear skip wrong");

  a_skip_rbs_none: assert property (
    i_valid && !o_busy &&
    i_instr.op == cmp_skip_branch_pkg::OP_SKIP_REG_BIT_SET &&
    !i_instr.rd_val[i_instr.bit_sel] |=> !o_pc_we && o_done && !o_flags_we)
    else $error("register bit set skip taken wrongly");

  a_skip_iobc_three: assert property (
    i_valid && !o_busy &&
    i_instr.op == cmp_skip_branch_pkg::OP_SKIP_IO_BIT_CLEAR &&
    !i_instr.io_val[i_instr.bit_sel] && i_instr.next_is_two_word
    |=> o_pc_we && o_pc == $past(i_pc) + 16'h0003 ##1 !o_done ##1 o_done)
    else $error("io bit clear two word skip wrong");

  a_skip_iobs_pc: assert property (
    i_valid && !o_busy &&
    i_instr.op == cmp_skip_branch_pkg::OP_SKIP_IO_BIT_SET &&
    i_instr.io_val[i_instr.bit_sel] |=> o_pc_we && !o_flags_we)
    else $error("io bit set skip not taken");

  a_branch_set_pc: assert property (
    i_valid && !o_busy &&
    i_instr.op == cmp_skip_branch_pkg::OP_BRANCH_EQUAL &&
    i_flags[cmp_skip_branch_pkg::FLAG_Z]
    |=> o_pc_we && o_pc == $past(i_pc) + $past(k_ext) + 16'h0001 ##1 o_done)
    else $error("branch on equal target wrong");

  a_branch_clr_not: assert property (
    i_valid && !o_busy &&
    i_instr.op == cmp_skip_branch_pkg::OP_BRANCH_NOT_EQUAL &&
    i_flags[cmp_skip_branch_pkg::FLAG_Z] |=> !o_pc_we && o_done)
    else $error("branch not equal taken wrongly");

endmodule // compare_skip_branch_exec

`default_nettype wire

// File: verification/core_state_model.sv
// partner: program counter and status register of the core
`timescale 1ns/1ps
`default_nettype none
module core_state_model (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_load,
  input wire logic [15:0] i_load_pc,
  input wire logic [7:0] i_load_flags,
  input wire logic i_pc_we,
  input wire logic [15:0] i_pc,
  input wire logic i_flags_we,
  input wire logic [7:0] i_flags,
  output logic [15:0] o_pc,
  output logic [7:0] o_flags
);
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst || i_load)
    begin
      o_pc <= i_srst ? 16'h0000 : i_load_pc;
      o_flags <= i_srst ? 8'h00 : i_load_flags;
    end
    else
    begin
      if (i_pc_we) o_pc <= i_pc;
      if (i_flags_we) o_flags <= i_flags;
    end
  end
endmodule // core_state_model
`default_nettype wire

// File: verification/compare_skip_branch_exec_bench.sv
// bench: random instructions checked against an integer model
`timescale 1ns/1ps
`default_nettype none
module compare_skip_branch_exec_bench;
  logic clk, srst, valid, busy, done, fwe, pwe, load;
  logic [7:0] fl_o, fl, ld_fl, res, b, e_fl, f;
  logic [15:0] pc_o, pc, ld_pc, e_pc;
  logic [31:0] rnd;
  cmp_skip_branch_pkg::instr_t ins;
  int errors, cmp_count, lat, nfw, npw, e_lat, e_fw, e_pw, r, s, cat;
  compare_skip_branch_exec i_compare_skip_branch_exec (.i_clk_sys(clk),
    .i_srst(srst), .i_valid(valid), .i_instr(ins), .i_pc(pc),
    .i_flags(fl), .o_busy(busy), .o_done(done), .o_flags_we(fwe),
    .o_flags(fl_o), .o_pc_we(pwe), .o_pc(pc_o));
  core_state_model i_core_state_model (.i_clk_sys(clk), .i_srst(srst),
    .i_load(load), .i_load_pc(ld_pc), .i_load_flags(ld_fl),
    .i_pc_we(pwe), .i_pc(pc_o), .i_flags_we(fwe), .i_flags(fl_o),
    .o_pc(pc), .o_flags(fl));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic judge();
    chk(16'(lat), 16'(e_lat));
    chk(16'(nfw), 16'(e_fw));
    chk(16'(npw), 16'(e_pw));
    chk(pc, e_pc);
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #(3000 * 100);
    errors++;
    stop_test();
  end
  initial
  begin
    {srst, valid, load, ld_pc, ld_fl, ins} = '0;
    srst = 1'b1;
    rnd = 32'h5a02;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    repeat (250)
    begin
      @(negedge clk);
      valid = 1'b0;
      load = 1'b1;
      ld_pc = rnd[15:0];
      ld_fl = rnd[23:16];
      rnd = lfsr(rnd);
      @(negedge clk);
      load = 1'b0;
      ins.op = cmp_skip_branch_pkg::op_t'(4'(rnd[30:27] % 12));
      {ins.io_val, ins.imm_k, ins.rr_val, ins.rd_val} = rnd;
      rnd = lfsr(rnd);
      {ins.next_is_two_word, ins.offset_k, ins.bit_sel} = rnd[10:0];
      rnd = lfsr(rnd);
      valid = 1'b1;
      f = ld_fl;
      e_pc = ld_pc;
      {e_fw, e_pw, e_lat, e_fl} = '0;
      cat = (ins.op == 4'h0) ? 3 : (ins.op < 4'h3) ? 0
        : (ins.op < 4'h7) ? 1 : 2;
      e_lat = (cat == 3) ? 0 : 1;
      if (cat == 0)
      begin
        b = (ins.op == 4'h1) ? ins.rr_val : ins.imm_k;
        r = int'(ins.rd_val) - int'(b) - ((ins.op == 4'h1) ? int'(f[0]) : 0);
        res = 8'(r);
        e_fl = f;
        e_fl[0] = r < 0;
        e_fl[1] = (res == 8'h00) && (ins.op == 4'h2 || f[1]);
        e_fl[2] = res[7];
        e_fl[3] = (ins.rd_val[7] & ~b[7] & ~res[7]) |
          (~ins.rd_val[7] & b[7] & res[7]);
        e_fl[4] = e_fl[2] ^ e_fl[3];
        e_fl[5] = (~ins.rd_val[3] & b[3]) | (b[3] & res[3]) |
          (res[3] & ~ins.rd_val[3]);
        e_fw = 1;
      end
      else if (cat != 3)
      begin
        if (cat == 1)
          s = ((ins.op < 4'h5) ? ins.rd_val[ins.bit_sel]
            : ins.io_val[ins.bit_sel]) == (ins.op == 4'h4 || ins.op == 4'h6);
        else
          s = f[(ins.op == 4'h9 || ins.op == 4'hA) ? 1
            : (ins.op == 4'hB) ? 0 : int'(ins.bit_sel)]
            == (ins.op != 4'h8 && ins.op != 4'hA);
        if (s != 0)
        begin
          e_pw = 1;
          e_lat = (cat == 1 && ins.next_is_two_word) ? 3 : 2;
          e_pc = (cat == 2) ? ld_pc + {{9{ins.offset_k[6]}}, ins.offset_k}
            + 16'h0001 : ld_pc + 16'(e_lat);
        end
      end
      {lat, nfw, npw} = '0;
      @(posedge clk);
      for (int n = 1; n < 6 && lat == 0; n++)
      begin
        @(negedge clk);
        if (fwe === 1'b1) nfw++;
        if (fwe === 1'b1) chk(16'(fl_o), 16'(e_fl));
        if (pwe === 1'b1) npw++;
        if (done === 1'b1) lat = n;
        chk(16'(busy), 16'(n < e_lat));
        ins.op = cmp_skip_branch_pkg::OP_COMPARE_IMMEDIATE;
        valid = busy;
      end
      @(negedge clk);
      if (cat == 0 || cat == 3) judge();
      if (cat == 1) judge();
      if (cat == 2) judge();
    end
    stop_test();
  end
endmodule // compare_skip_branch_exec_bench
`default_nettype wire
